//--- umcs_top.sv
`timescale 1ns/1ps
`include "umcs_cfg.svh"

// How it works
// [R01] Control bit 0 set drives dtr low.
// [R02] Control bit 1 set drives rts low.
// [R03] Control bit 2 set drives user_output_one low.
// [R04] Interrupt passes only while bit 3 set.
// [R05] Loopback: tx high, rx from tx shift.
// [R06] Loopback: handshake inputs from controls, outputs high.
// [R07] Loopback handshake interrupts come only from control writes.
// [R08] Loopback status 4..7 shows rts,dtr,user_output_one,user_output_two.
// [R09] Control bits 5..7 always read zero.
// [R10] Status 4..7 are complemented handshake inputs.
// [R11] Cts, dsr, dcd changes set sticky deltas.
// [R12] Ring delta only on low-to-high edge.
// [R13] Enabled delta raises level-four interrupt.
// [R14] Status read clears deltas, keeps levels.
// [R15] Conditions during a read set afterwards.
// [R16] Set bit recurring in read ends cleared.
// [R17] Host must not write the status register.
// [R18] Divider yields strobe per divisor clocks.
// [R19] Divisor held as two byte latches.
// [R20] Divisor byte write reloads counter immediately.
// [R21] Host programs both divisor bytes first.
// [R22] Reset clears the whole control register.
// [R23] Reset clears deltas; levels follow inputs.
// [R24] Strobe one clock wide for divisors above 1; counter reloads on the edge that raises it.
module umcs_top
    import umcs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    input wire logic cts_n,
    input wire logic dsr_n,
    input wire logic ri_n,
    input wire logic dcd_n,
    output logic dtr_n,
    output logic rts_n,
    output logic user_output_one,
    output logic user_output_two,
    input wire logic chan_irq,
    input wire logic handshake_irq_enable,
    output logic irq_out,
    output logic handshake_irq,
    input wire logic serial_rx_pin,
    input wire logic tx_shift_out,
    output logic serial_tx_pin,
    output logic rx_shift_in,
    output logic rate_strobe
);

    // Host strobes and handshake pins arrive asynchronously: two flops each.
    logic [3:0] pin_s1_r, pin_s2_r;
    logic [2:0] bus_s1_r, bus_s2_r;
    logic rx_s1_r, rx_s2_r;
    logic rd_q_r;
    umcs_bus_type bus;
    umcs_lines_type pins_act, lines, lines_r;
    logic [7:0] ctrl_r;
    logic [3:0] delta_r, delta_nxt, cond;
    logic [7:0] div_lo_r, div_hi_r;
    logic [15:0] cnt_r, cnt_nxt;
    logic loop_on, rd_now, rd_end, stat_rd, div_wr, ctrl_wr, expire;
    logic [7:0] stat_val, rdata_nxt;

    always_ff @(posedge sys_clk) begin
        pin_s1_r <= {dcd_n, ri_n, dsr_n, cts_n};
        pin_s2_r <= pin_s1_r;
        bus_s1_r <= {~read_strobe_n, ~write_strobe_n, chan_irq};
        bus_s2_r <= bus_s1_r;
        rx_s1_r <= serial_rx_pin;
        rx_s2_r <= rx_s1_r;
    end

    // Address and data are taken stable while the synchronised strobe is held.
    assign bus = '{rd: bus_s2_r[2], wr: bus_s2_r[1], addr: addr, wdata: wdata};
    assign pins_act = ~pin_s2_r;

    logic wr_q_r;
    wire wr_edge = bus.wr & ~wr_q_r;
    assign ctrl_wr = wr_edge && bus.addr == `UMCS_IDX_CTRL;
    assign div_wr = wr_edge && (bus.addr == `UMCS_IDX_DIV_LO || bus.addr == `UMCS_IDX_DIV_HI);
    assign rd_now = bus.rd;
    assign rd_end = rd_q_r & ~bus.rd;
    assign stat_rd = bus.addr == `UMCS_IDX_STAT;
    assign loop_on = ctrl_r[`UMCS_CTRL_LOOP];

    // Loopback maps rts->cts, dtr->dsr, user_output_one->ri, user_output_two->dcd.
    assign lines = loop_on ? '{dcd: ctrl_r[`UMCS_CTRL_USER2], ri: ctrl_r[`UMCS_CTRL_USER1],
                               dsr: ctrl_r[`UMCS_CTRL_DTR], cts: ctrl_r[`UMCS_CTRL_RTS]}
                           : pins_act; // see [R06] see [R07] see [R08] see [R10]

    assign cond[`UMCS_STAT_DCTS] = lines.cts ^ lines_r.cts; // see [R11]
    assign cond[`UMCS_STAT_DDSR] = lines.dsr ^ lines_r.dsr; // see [R11]
    assign cond[`UMCS_STAT_RING_TRAILING_EDGE_FLAG] = ~lines.ri & lines_r.ri; // see [R12]
    assign cond[`UMCS_STAT_DDCD] = lines.dcd ^ lines_r.dcd; // see [R11]

    // Conditions seen during a status read are held back, then applied at its end.
    logic [3:0] pend_r, pend_nxt, seen_set_r, seen_set_nxt;
    logic rd_q_stat_r;
    wire in_stat_rd = rd_now & stat_rd;
    assign pend_nxt = in_stat_rd ? pend_r | (cond & ~delta_r & ~seen_set_r) : 4'h0; // see [R15]
    assign seen_set_nxt = in_stat_rd ? seen_set_r | delta_r : 4'h0;
    // At the trailing edge deltas clear; ones set before the read stay cleared.
    always_comb begin
        if (rd_end && rd_q_stat_r) begin
            delta_nxt = pend_r | (cond & ~seen_set_r); // see [R14] see [R16]
        end else if (in_stat_rd) begin
            delta_nxt = delta_r; // see [R15]
        end else begin
            delta_nxt = delta_r | cond;
        end
    end

    assign stat_val = {lines, delta_r};
    assign rdata_nxt = !rd_now ? rdata :
                       bus.addr == `UMCS_IDX_CTRL ? ctrl_r & `UMCS_CTRL_WMASK : // see [R09]
                       bus.addr == `UMCS_IDX_STAT ? stat_val :
                       bus.addr == `UMCS_IDX_DIV_LO ? div_lo_r :
                       bus.addr == `UMCS_IDX_DIV_HI ? div_hi_r : 8'h00;

    wire [15:0] divisor = {div_hi_r, div_lo_r}; // see [R19]
    wire [15:0] wr_div_val = bus.addr == `UMCS_IDX_DIV_LO ? {div_hi_r, bus.wdata}
                                                         : {bus.wdata, div_lo_r};

    // A zero divisor would stall the counter, so it runs as one; software loads 1..65535.
    function automatic logic [15:0] umcs_div_eff(input logic [15:0] v);
        return (v == 16'h0000) ? 16'h0001 : v;
    endfunction : umcs_div_eff

    assign expire = cnt_r <= 16'h0001;
    assign cnt_nxt = div_wr ? umcs_div_eff(wr_div_val) : // see [R20]
                     expire ? umcs_div_eff(divisor) : // see [R24]
                     cnt_r - 16'h0001; // see [R18]

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ctrl_r <= `UMCS_CTRL_RST; // see [R22]
            delta_r <= 4'h0; // see [R23]
            pend_r <= 4'h0;
            seen_set_r <= 4'h0;
            rd_q_r <= 1'b0;
            rd_q_stat_r <= 1'b0;
            wr_q_r <= 1'b0;
            // Tracking the lines through reset keeps a false delta from following it.
            lines_r <= lines;
            cnt_r <= `UMCS_DIV_RST;
            rdata <= 8'h00;
        end else begin
            if (ctrl_wr) begin
                ctrl_r <= bus.wdata & `UMCS_CTRL_WMASK; // see [R03] see [R09]
            end
            delta_r <= delta_nxt;
            pend_r <= pend_nxt;
            seen_set_r <= seen_set_nxt;
            rd_q_r <= rd_now;
            rd_q_stat_r <= in_stat_rd;
            wr_q_r <= bus.wr;
            lines_r <= lines;
            cnt_r <= cnt_nxt;
            rdata <= rdata_nxt;
        end
    end

    // Divisor latches survive reset by design.
    always_ff @(posedge sys_clk) begin
        if (wr_edge && bus.addr == `UMCS_IDX_DIV_LO) begin
            div_lo_r <= bus.wdata;
        end
        if (wr_edge && bus.addr == `UMCS_IDX_DIV_HI) begin
            div_hi_r <= bus.wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            dtr_n <= 1'b1;
            rts_n <= 1'b1;
            user_output_one <= 1'b1;
            user_output_two <= 1'b1;
            serial_tx_pin <= 1'b1;
            rx_shift_in <= 1'b1;
            irq_out <= 1'b0;
            handshake_irq <= 1'b0;
            rate_strobe <= 1'b0;
        end else begin
            dtr_n <= ~ctrl_r[`UMCS_CTRL_DTR] | loop_on; // see [R01] see [R06]
            rts_n <= ~ctrl_r[`UMCS_CTRL_RTS] | loop_on; // see [R02] see [R06]
            user_output_one <= ~ctrl_r[`UMCS_CTRL_USER1] | loop_on;
            user_output_two <= ~ctrl_r[`UMCS_CTRL_USER2] | loop_on;
            serial_tx_pin <= loop_on ? 1'b1 : tx_shift_out; // see [R05]
            rx_shift_in <= loop_on ? tx_shift_out : rx_s2_r; // see [R05]
            handshake_irq <= handshake_irq_enable & (|delta_r); // see [R13]
            irq_out <= bus_s2_r[0] & ctrl_r[`UMCS_CTRL_USER2]; // see [R04]
            rate_strobe <= expire & ~div_wr; // see [R24]
        end
    end

    // The divisor latches are not reset, so counter checks only bite once both are loaded.
    property p_dtr_follow;
        @(posedge sys_clk) disable iff (!rst_n)
        1'b1 |=> dtr_n == ($past(~ctrl_r[`UMCS_CTRL_DTR]) | $past(loop_on));
    endproperty
    a_dtr_follow: assert property (p_dtr_follow) else $error("dtr level wrong"); // see [R01]

    property p_rts_follow;
        @(posedge sys_clk) disable iff (!rst_n)
        1'b1 |=> rts_n == ($past(~ctrl_r[`UMCS_CTRL_RTS]) | $past(loop_on));
    endproperty
    a_rts_follow: assert property (p_rts_follow) else $error("rts level wrong"); // see [R02]

    property p_user_follow;
        @(posedge sys_clk) disable iff (!rst_n)
        1'b1 |=> user_output_one == ($past(~ctrl_r[`UMCS_CTRL_USER1]) | $past(loop_on))
            && user_output_two == ($past(~ctrl_r[`UMCS_CTRL_USER2]) | $past(loop_on));
    endproperty
    a_user_follow: assert property (p_user_follow) else $error("user out wrong"); // see [R03]

    property p_irq_block;
        @(posedge sys_clk) disable iff (!rst_n)
        !ctrl_r[`UMCS_CTRL_USER2] |=> !irq_out;
    endproperty
    a_irq_block: assert property (p_irq_block) else $error("irq leaked"); // see [R04]

    property p_irq_pass;
        @(posedge sys_clk) disable iff (!rst_n)
        (bus_s2_r[0] && ctrl_r[`UMCS_CTRL_USER2]) |=> irq_out;
    endproperty
    a_irq_pass: assert property (p_irq_pass) else $error("irq not passed"); // see [R04]

    property p_loop_tx;
        @(posedge sys_clk) disable iff (!rst_n)
        loop_on |=> serial_tx_pin;
    endproperty
    a_loop_tx: assert property (p_loop_tx) else $error("tx low in loopback"); // see [R05]

    property p_loop_rx;
        @(posedge sys_clk) disable iff (!rst_n)
        loop_on |=> rx_shift_in == $past(tx_shift_out);
    endproperty
    a_loop_rx: assert property (p_loop_rx) else $error("rx not looped"); // see [R05]

    property p_loop_pins;
        @(posedge sys_clk) disable iff (!rst_n)
        loop_on |=> dtr_n && rts_n && user_output_one && user_output_two;
    endproperty
    a_loop_pins: assert property (p_loop_pins) else $error("loop pins low"); // see [R06]

    property p_loop_quiet;
        @(posedge sys_clk) disable iff (!rst_n)
        (loop_on && $past(loop_on) && $stable(ctrl_r) && !in_stat_rd
            && !(rd_end && rd_q_stat_r)) |=> delta_r == $past(delta_r);
    endproperty
    a_loop_quiet: assert property (p_loop_quiet) else $error("pin delta in loop"); // see [R07]

    property p_loop_levels;
        @(posedge sys_clk) disable iff (!rst_n)
        loop_on |-> stat_val[7:4] == {ctrl_r[`UMCS_CTRL_USER2], ctrl_r[`UMCS_CTRL_USER1],
                                      ctrl_r[`UMCS_CTRL_DTR], ctrl_r[`UMCS_CTRL_RTS]};
    endproperty
    a_loop_levels: assert property (p_loop_levels) else $error("loop levels wrong"); // see [R08]

    property p_ctrl_high;
        @(posedge sys_clk) disable iff (!rst_n)
        ctrl_r[7:5] == 3'h0;
    endproperty
    a_ctrl_high: assert property (p_ctrl_high) else $error("ctrl high bits set"); // see [R09]

    property p_delta_set;
        @(posedge sys_clk) disable iff (!rst_n)
        (|cond && !in_stat_rd && !(rd_end && rd_q_stat_r))
            |=> (delta_r & $past(cond)) == $past(cond);
    endproperty
    a_delta_set: assert property (p_delta_set) else $error("delta not set"); // see [R11]

    property p_ri_fall;
        @(posedge sys_clk) disable iff (!rst_n)
        (lines.ri && !lines_r.ri && !in_stat_rd && !(rd_end && rd_q_stat_r)
            && !delta_r[`UMCS_STAT_RING_TRAILING_EDGE_FLAG]) |=> !delta_r[`UMCS_STAT_RING_TRAILING_EDGE_FLAG];
    endproperty
    a_ri_fall: assert property (p_ri_fall) else $error("ring_trailing_edge_flag on wrong edge"); // see [R12]

    property p_hirq_on;
        @(posedge sys_clk) disable iff (!rst_n)
        (handshake_irq_enable && |delta_r) |=> handshake_irq;
    endproperty
    a_hirq_on: assert property (p_hirq_on) else $error("no status irq"); // see [R13]

    property p_hirq_off;
        @(posedge sys_clk) disable iff (!rst_n)
        !(handshake_irq_enable && |delta_r) |=> !handshake_irq;
    endproperty
    a_hirq_off: assert property (p_hirq_off) else $error("spurious status irq"); // see [R13]

    property p_read_clear;
        @(posedge sys_clk) disable iff (!rst_n)
        (rd_end && rd_q_stat_r && pend_r == 4'h0 && cond == 4'h0) |=> delta_r == 4'h0;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("read no clear"); // see [R14]

    property p_read_hold;
        @(posedge sys_clk) disable iff (!rst_n)
        in_stat_rd |=> delta_r == $past(delta_r);
    endproperty
    a_read_hold: assert property (p_read_hold) else $error("set during read"); // see [R15]

    property p_read_recur;
        @(posedge sys_clk) disable iff (!rst_n)
        (rd_end && rd_q_stat_r) |=> (delta_r & $past(seen_set_r)) == 4'h0;
    endproperty
    a_read_recur: assert property (p_read_recur) else $error("recurring bit set"); // see [R16]

    property p_count_down;
        @(posedge sys_clk) disable iff (!rst_n)
        (!div_wr && !expire) |=> cnt_r == $past(cnt_r) - 16'h0001;
    endproperty
    a_count_down: assert property (p_count_down) else $error("counter skipped"); // see [R18]

    property p_reload;
        @(posedge sys_clk) disable iff (!rst_n)
        div_wr |=> !rate_strobe;
    endproperty
    a_reload: assert property (p_reload) else $error("strobe on reload"); // see [R20]

    property p_strobe_width;
        @(posedge sys_clk) disable iff (!rst_n)
        (rate_strobe && divisor > 16'h0001) |=> !rate_strobe;
    endproperty
    a_strobe_width: assert property (p_strobe_width) else $error("strobe too wide"); // see [R24]

    property p_reset_ctrl;
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(rst_n) |-> ctrl_r == `UMCS_CTRL_RST && dtr_n && rts_n
            && user_output_one && user_output_two;
    endproperty
    a_reset_ctrl: assert property (p_reset_ctrl) else $error("ctrl not reset"); // see [R22]

    property p_reset_delta;
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(rst_n) |-> delta_r == 4'h0;
    endproperty
    a_reset_delta: assert property (p_reset_delta) else $error("deltas not reset"); // see [R23]

    c_loop: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(loop_on));
    c_strobe: cover property (@(posedge sys_clk) disable iff (!rst_n) rate_strobe);
    c_delta: cover property (@(posedge sys_clk) disable iff (!rst_n) |delta_r);
    c_read: cover property (@(posedge sys_clk) disable iff (!rst_n) rd_end && rd_q_stat_r);

endmodule : umcs_top

//--- umcs_cfg.svh
`ifndef UMCS_CFG_SVH
`define UMCS_CFG_SVH

// Register indices on the 3-bit address lines of the channel.
`define UMCS_IDX_DIV_LO 3'h0
`define UMCS_IDX_DIV_HI 3'h1
`define UMCS_IDX_CTRL 3'h4
`define UMCS_IDX_STAT 3'h6

// Handshake control register fields.
`define UMCS_CTRL_DTR 0
`define UMCS_CTRL_RTS 1
`define UMCS_CTRL_USER1 2
`define UMCS_CTRL_USER2 3
`define UMCS_CTRL_LOOP 4
`define UMCS_CTRL_RST 8'h00
`define UMCS_CTRL_WMASK 8'h1f

// Handshake status register fields.
`define UMCS_STAT_DCTS 0
`define UMCS_STAT_DDSR 1
`define UMCS_STAT_RING_TRAILING_EDGE_FLAG 2
`define UMCS_STAT_DDCD 3

`define UMCS_DIV_RST 16'h0001

`endif

//--- umcs_pkg.sv
package umcs_pkg;

    // Handshake lines in status-bit order: cts, dsr, ri, dcd.
    typedef struct packed {
        logic dcd;
        logic ri;
        logic dsr;
        logic cts;
    } umcs_lines_type;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [2:0] addr;
        logic [7:0] wdata;
    } umcs_bus_type;

endpackage : umcs_pkg

//--- umcs_modem.sv
`timescale 1ns/1ps
module umcs_modem
    import umcs_pkg::*;
(
    input wire logic sys_clk,
    input wire umcs_lines_type want,
    output logic cts_n,
    output logic dsr_n,
    output logic ri_n,
    output logic dcd_n
);
    // The set drives its lines from its first clock edge on; before that edge each line is unknown.
    always_ff @(posedge sys_clk) begin
        cts_n <= ~want.cts;
        dsr_n <= ~want.dsr;
        ri_n <= ~want.ri;
        dcd_n <= ~want.dcd;
    end
endmodule : umcs_modem

//--- uart_modem_ctrl_status_baud_test.sv
`timescale 1ns/1ps
`include "umcs_cfg.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module uart_modem_ctrl_status_baud_test
    import umcs_pkg::*;
;
    logic sys_clk = 1'b0, rst_n = 1'b0, rs_n = 1'b1, ws_n = 1'b1;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00, rdata, d;
    logic cts_n, dsr_n, ri_n, dcd_n, dtr_n, rts_n, uo1, uo2, chan_irq = 1'b0, hie = 1'b0;
    logic irq_out, hs_irq, rx_pin = 1'b1, tx_sh = 1'b1, tx_pin, rx_sh, rate_strobe;
    umcs_lines_type want = 4'h0;
    int n_mismatch = 0, n_checks = 0, n;
    always #2.5 sys_clk = ~sys_clk;
    umcs_modem modem_u (.sys_clk(sys_clk), .want(want), .cts_n(cts_n), .dsr_n(dsr_n),
        .ri_n(ri_n), .dcd_n(dcd_n));
    umcs_top dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .read_strobe_n(rs_n),
        .write_strobe_n(ws_n), .addr(addr), .wdata(wdata), .rdata(rdata), .cts_n(cts_n),
        .dsr_n(dsr_n), .ri_n(ri_n), .dcd_n(dcd_n), .dtr_n(dtr_n), .rts_n(rts_n),
        .user_output_one(uo1), .user_output_two(uo2), .chan_irq(chan_irq),
        .handshake_irq_enable(hie), .irq_out(irq_out), .handshake_irq(hs_irq),
        .serial_rx_pin(rx_pin), .tx_shift_out(tx_sh), .serial_tx_pin(tx_pin),
        .rx_shift_in(rx_sh), .rate_strobe(rate_strobe));
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        addr <= a;
        wdata <= v;
        ws_n <= 1'b0;
        repeat (4) @(posedge sys_clk);
        ws_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
    endtask : wr
    // Strobes pass a two-flop synchroniser, so the answer is read well after it settles.
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        addr <= a;
        rs_n <= 1'b0;
        repeat (5) @(posedge sys_clk);
        #1 `CHK("rdata", e, rdata)
        @(posedge sys_clk);
        rs_n <= 1'b1;
        repeat (5) @(posedge sys_clk);
    endtask : rd
    task automatic settle;
        repeat (8) @(posedge sys_clk);
        #1;
    endtask : settle
    task automatic t_control;
        rd(`UMCS_IDX_CTRL, 8'h00);
        rd(`UMCS_IDX_STAT, 8'h00);
        `CHK("pins", 4'hf, {dtr_n, rts_n, uo1, uo2})
        wr(`UMCS_IDX_CTRL, 8'hff);
        rd(`UMCS_IDX_CTRL, 8'h1f);
        `CHK("pins", 4'hf, {dtr_n, rts_n, uo1, uo2})
        wr(`UMCS_IDX_CTRL, 8'h0f);
        chan_irq <= 1'b1;
        settle();
        `CHK("pins", 4'h0, {dtr_n, rts_n, uo1, uo2})
        `CHK("irq_out", 1'b1, irq_out)
        wr(`UMCS_IDX_CTRL, 8'h03);
        settle();
        `CHK("irq_out", 1'b0, irq_out)
        `CHK("pins", 4'h3, {dtr_n, rts_n, uo1, uo2})
        wr(`UMCS_IDX_CTRL, 8'h00);
        rd(`UMCS_IDX_CTRL, 8'h00);
        // Leaving loopback drops the looped ring level, which is a trailing edge.
        rd(`UMCS_IDX_STAT, 8'h0f);
        // The host never writes the status register; a plain re-read shows it cleared.
        rd(`UMCS_IDX_STAT, 8'h00);
    endtask : t_control
    task automatic t_status;
        @(posedge sys_clk);
        hie <= 1'b1;
        want.cts <= 1'b1;
        settle();
        `CHK("hs_irq", 1'b1, hs_irq)
        rd(`UMCS_IDX_STAT, 8'h11);
        rd(`UMCS_IDX_STAT, 8'h10);
        `CHK("hs_irq", 1'b0, hs_irq)
        want.ri <= 1'b1;
        settle();
        rd(`UMCS_IDX_STAT, 8'h50);
        want.ri <= 1'b0;
        want.cts <= 1'b0;
        want.dsr <= 1'b1;
        settle();
        rd(`UMCS_IDX_STAT, 8'h27);
        want <= 4'h0;
        settle();
        rd(`UMCS_IDX_STAT, 8'h02);
    endtask : t_status
    task automatic t_loop;
        wr(`UMCS_IDX_CTRL, 8'h1f);
        rx_pin <= 1'b0;
        want.dcd <= 1'b1;
        settle();
        rd(`UMCS_IDX_STAT, 8'hfb);
        `CHK("pins", 4'hf, {dtr_n, rts_n, uo1, uo2})
        `CHK("tx_pin", 1'b1, tx_pin)
        `CHK("rx_sh", 1'b1, rx_sh)
        @(posedge sys_clk);
        tx_sh <= 1'b0;
        settle();
        `CHK("rx_sh", 1'b0, rx_sh)
        wr(`UMCS_IDX_CTRL, 8'h10);
        want.dcd <= 1'b0;
        rd(`UMCS_IDX_STAT, 8'h0f);
        wr(`UMCS_IDX_CTRL, 8'h00);
        tx_sh <= 1'b1;
        rd(`UMCS_IDX_STAT, 8'h00);
    endtask : t_loop
    task automatic period(input int e);
        for (n = 0; n < 600 && rate_strobe !== 1'b1; n++) @(posedge sys_clk) #1;
        @(posedge sys_clk) #1;
        `CHK("width", 1'b0, rate_strobe)
        for (n = 1; n < 600 && rate_strobe !== 1'b1; n++) @(posedge sys_clk) #1;
        `CHK("period", e, n)
    endtask : period
    task automatic t_divider;
        wr(`UMCS_IDX_DIV_LO, 8'h05);
        wr(`UMCS_IDX_DIV_HI, 8'h00);
        period(5);
        wr(`UMCS_IDX_DIV_HI, 8'h01);
        period(261);
    endtask : t_divider
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run
    initial begin
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_control();
        t_status();
        t_loop();
        t_divider();
        complete_run();
    end
    initial begin
        #100000;
        n_mismatch++;
        complete_run();
    end
endmodule : uart_modem_ctrl_status_baud_test
